// ==== design/twu_key_seq.sv ====
// Two-key sequencer that opens the timed write window
`timescale 1ns/10ps
module twu_key_seq #(
  parameter int ARM_CYCLES  = twu_pkg::ARM_MC,
  parameter int OPEN_CYCLES = twu_pkg::OPEN_MC
) (
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   key_we_i,
  input  wire logic [7:0]             key_data_i,
  output logic                        window_open_o,
  output logic                        armed_o
);

  typedef enum logic [2:0] {
    TWU_IDLE  = 3'b001,
    TWU_ARMED = 3'b010,
    TWU_OPEN  = 3'b100
  } twu_state_type;

  twu_state_type                 state_ff;
  twu_state_type                 nxt_state;
  logic [twu_pkg::CNT_W-1:0]     cnt_ff;
  logic [twu_pkg::CNT_W-1:0]     nxt_cnt;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      TWU_IDLE: begin
        if (key_we_i && key_data_i == twu_pkg::KEY_FIRST) begin
          nxt_state = TWU_ARMED;
          nxt_cnt   = twu_pkg::CNT_W'(ARM_CYCLES);
        end
      end
      TWU_ARMED: begin
        // second key in time opens window
        if (key_we_i && key_data_i == twu_pkg::KEY_SECOND) begin
          nxt_state = TWU_OPEN;
          nxt_cnt   = twu_pkg::CNT_W'(OPEN_CYCLES);
        end else if (key_we_i && key_data_i == twu_pkg::KEY_FIRST) begin
          nxt_cnt   = twu_pkg::CNT_W'(ARM_CYCLES);
        end else if (key_we_i) begin
          nxt_state = TWU_IDLE;
          nxt_cnt   = '0;
        // late second key finds arming expired
        end else if (cnt_ff == twu_pkg::CNT_W'(1)) begin
          nxt_state = TWU_IDLE;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt   = cnt_ff - twu_pkg::CNT_W'(1);
        end
      end
      TWU_OPEN: begin
        if (key_we_i && key_data_i == twu_pkg::KEY_FIRST) begin
          nxt_state = TWU_ARMED;
          nxt_cnt   = twu_pkg::CNT_W'(ARM_CYCLES);
        end else if (key_we_i) begin
          nxt_state = TWU_IDLE;
          nxt_cnt   = '0;
        end else if (cnt_ff == twu_pkg::CNT_W'(1)) begin
          nxt_state = TWU_IDLE;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt   = cnt_ff - twu_pkg::CNT_W'(1);
        end
      end
      default: begin
        nxt_state = TWU_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= TWU_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign window_open_o = (state_ff == TWU_OPEN);
  assign armed_o       = (state_ff == TWU_ARMED);

endmodule : twu_key_seq

// ==== design/twu_pkg.sv ====
// Shared constants and types for the timed write unlock guard
package twu_pkg;

  // ==========================================================================
  // Register map (printed offsets are indices; byte address is index * 4)
  // ==========================================================================
  localparam logic [7:0]  UNLOCK_KEY_IDX   = 8'hc7;
  localparam logic [7:0]  WD_CTRL_IDX      = 8'hd8;
  localparam logic [7:0]  GUARD_STATUS_IDX = 8'hd9;
  localparam int          ADDR_W           = 12;
  localparam int          IDX_LSB          = 2;

  // ==========================================================================
  // Keys and timing
  // ==========================================================================
  localparam logic [7:0]  KEY_FIRST        = 8'haa;
  localparam logic [7:0]  KEY_SECOND       = 8'h55;
  localparam int          ARM_MC           = 3;
  localparam int          OPEN_MC          = 3;
  localparam int          CNT_W            = 2;

  // ==========================================================================
  // Protected control field layout
  // ==========================================================================
  localparam int          WDC_RST_EN_BIT   = 0;
  localparam int          WDC_RUN_BIT      = 1;
  localparam int          WDC_WAIT_LSB     = 2;
  localparam int          WDC_POR_BIT      = 7;
  localparam logic [2:0]  WAIT_RESET       = 3'h0;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;

  typedef struct packed {
    logic       por_flag;
    logic [2:0] wait_states;
    logic       wd_run;
    logic       watchdog_reset_enable;
  } twu_ctrl_type;

  localparam twu_ctrl_type CTRL_RESET = '{por_flag: 1'b1, wait_states: WAIT_RESET,
                                         wd_run: 1'b0, watchdog_reset_enable: 1'b0};

  typedef struct packed {
    logic armed;
    logic window_open;
  } twu_status_type;

endpackage : twu_pkg

// ==== design/twu_top.sv ====
// Timed write unlock guard with AXI4-Lite register slave
`timescale 1ns/10ps
module twu_top #(
  parameter int AW = twu_pkg::ADDR_W
) (
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  // AXI4-Lite slave
  input  wire logic [AW-1:0]          s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [AW-1:0]          s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Power-fail event, sets the reset flag
  input  wire logic                   power_fail_i,
  // Protected controls and guard status
  output twu_pkg::twu_ctrl_type       ctrl_o,
  output twu_pkg::twu_status_type     status_o
);

  function automatic logic [7:0] reg_index(input logic [AW-1:0] addr);
    reg_index = addr[twu_pkg::IDX_LSB +: 8];
  endfunction : reg_index

  function automatic logic addr_mapped(input logic [AW-1:0] addr);
    logic [7:0] idx;
    idx = reg_index(addr);
    addr_mapped = (idx == twu_pkg::UNLOCK_KEY_IDX) || (idx == twu_pkg::WD_CTRL_IDX) ||
                  (idx == twu_pkg::GUARD_STATUS_IDX);
  endfunction : addr_mapped

  logic                       wr_fire;
  logic                       rd_fire;
  logic                       key_we;
  logic                       ctrl_we;
  logic                       window_open;
  logic                       armed;
  logic                       bvalid_ff;
  logic                       nxt_bvalid;
  logic [1:0]                 bresp_ff;
  logic [1:0]                 nxt_bresp;
  logic                       rvalid_ff;
  logic                       nxt_rvalid;
  logic [31:0]                rdata_ff;
  logic [31:0]                nxt_rdata;
  logic [1:0]                 rresp_ff;
  logic [1:0]                 nxt_rresp;
  twu_pkg::twu_ctrl_type      ctrl_ff;
  twu_pkg::twu_ctrl_type      nxt_ctrl;

  // ==========================================================================
  // Write channel: address and data taken together
  // ==========================================================================
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign key_we  = wr_fire && s_axi_wstrb[0] &&
                   (reg_index(s_axi_awaddr) == twu_pkg::UNLOCK_KEY_IDX);
  assign ctrl_we = wr_fire && s_axi_wstrb[0] &&
                   (reg_index(s_axi_awaddr) == twu_pkg::WD_CTRL_IDX);

  always_comb begin
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (wr_fire) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = addr_mapped(s_axi_awaddr) ? twu_pkg::RESP_OKAY : twu_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Key sequencer
  // ==========================================================================
  twu_key_seq #(
    .ARM_CYCLES  (twu_pkg::ARM_MC),
    .OPEN_CYCLES (twu_pkg::OPEN_MC)
  ) u_key_seq (
    .clock_i       (clock_i),
    .arst_n_i      (arst_n_i),
    .key_we_i      (key_we),
    .key_data_i    (s_axi_wdata[7:0]),
    .window_open_o (window_open),
    .armed_o       (armed)
  );

  // ==========================================================================
  // Protected controls
  // ==========================================================================
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_we && window_open) begin
      nxt_ctrl.watchdog_reset_enable = s_axi_wdata[twu_pkg::WDC_RST_EN_BIT];
      nxt_ctrl.wd_run                = s_axi_wdata[twu_pkg::WDC_RUN_BIT];
      nxt_ctrl.wait_states           = s_axi_wdata[twu_pkg::WDC_WAIT_LSB +: 3];
      nxt_ctrl.por_flag              = s_axi_wdata[twu_pkg::WDC_POR_BIT];
    end
    // Hardware set beats software clear
    if (power_fail_i) begin
      nxt_ctrl.por_flag = 1'b1;
    end
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  assign rd_fire       = s_axi_arvalid && !rvalid_ff;
  assign s_axi_arready = rd_fire;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rd_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = addr_mapped(s_axi_araddr) ? twu_pkg::RESP_OKAY : twu_pkg::RESP_DECERR;
      nxt_rdata  = '0;
      if (reg_index(s_axi_araddr) == twu_pkg::WD_CTRL_IDX) begin
        nxt_rdata[twu_pkg::WDC_RST_EN_BIT]     = ctrl_ff.watchdog_reset_enable;
        nxt_rdata[twu_pkg::WDC_RUN_BIT]        = ctrl_ff.wd_run;
        nxt_rdata[twu_pkg::WDC_WAIT_LSB +: 3]  = ctrl_ff.wait_states;
        nxt_rdata[twu_pkg::WDC_POR_BIT]        = ctrl_ff.por_flag;
      end else if (reg_index(s_axi_araddr) == twu_pkg::GUARD_STATUS_IDX) begin
        nxt_rdata[1:0] = {armed, window_open};
      end
    end else if (s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= twu_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= twu_pkg::RESP_OKAY;
      ctrl_ff   <= twu_pkg::CTRL_RESET;
    end else begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      ctrl_ff   <= nxt_ctrl;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;
  assign ctrl_o       = ctrl_ff;
  assign status_o     = '{armed: armed, window_open: window_open};

endmodule : twu_top

// ==== sim/tb_twu_top.sv ====
// Self-checking bench for the timed write unlock guard
`timescale 1ns/10ps
module tb_twu_top;
  localparam logic [11:0] KEY_A = 12'h31c;
  localparam logic [11:0] WDC_A = 12'h360;
  localparam logic [11:0] STS_A = 12'h364;
  localparam logic [1:0]  OK    = twu_pkg::RESP_OKAY;
  logic                    clock_i  = 1'b0;
  logic                    arst_n_i = 1'b0;
  logic [11:0]             awaddr   = 12'h000;
  logic [11:0]             araddr   = 12'h000;
  logic [31:0]             wdata    = 32'h0000_0000;
  logic [3:0]              wstrb    = 4'hf;
  logic                    awvalid  = 1'b0;
  logic                    wvalid   = 1'b0;
  logic                    arvalid  = 1'b0;
  logic                    pfail    = 1'b0;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp;
  logic [31:0]             rdata;
  twu_pkg::twu_ctrl_type   ctrl;
  twu_pkg::twu_status_type sts;
  twu_pkg::twu_ctrl_type   exp_ctrl = twu_pkg::CTRL_RESET;
  int                      failures = 0;
  int                      check_count = 0;

  twu_top twu_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .power_fail_i(pfail), .ctrl_o(ctrl), .status_o(sts));

  always #2 clock_i = ~clock_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Wait on one ready or valid flag, bounded
  task automatic wait_flag(ref logic f, inout int n);
    do begin
      @(posedge clock_i);
      n++;
    end while (f !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      report_and_stop();
    end
  endtask : wait_flag

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wait_flag(awready, n);
    check(32'(wready), 32'h0000_0001);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_flag(bvalid, n);
    check(32'(bresp), 32'(er));
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    wait_flag(arready, n);
    arvalid <= 1'b0;
    wait_flag(rvalid, n);
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask : axi_read

  function automatic logic [31:0] wdc_word(input twu_pkg::twu_ctrl_type c);
    return {24'h00_0000, c.por_flag, 2'b00, c.wait_states, c.wd_run, c.watchdog_reset_enable};
  endfunction : wdc_word

  task automatic key(input logic [7:0] d);
    axi_write(KEY_A, d, 4'h1, OK);
  endtask : key

  task automatic ctl(input logic [7:0] v, input bit ok);
    axi_write(WDC_A, v, 4'h1, OK);
    if (ok) begin
      exp_ctrl = {v[7], v[4:0]};
    end
    check(32'(ctrl), 32'(exp_ctrl));
    axi_read(WDC_A, wdc_word(exp_ctrl), OK);
  endtask : ctl

  task automatic t_unlock(input int g1, input int g2, input logic [7:0] v, input bit ok);
    key(twu_pkg::KEY_FIRST);
    repeat (g1) @(posedge clock_i);
    key(twu_pkg::KEY_SECOND);
    repeat (g2) @(posedge clock_i);
    ctl(v, ok);
  endtask : t_unlock

  task automatic t_misc;
    key(twu_pkg::KEY_FIRST);
    axi_read(STS_A, 32'h0000_0002, OK);
    axi_read(STS_A, 32'h0000_0000, OK);
    key(twu_pkg::KEY_FIRST);
    key(8'h12);
    key(twu_pkg::KEY_SECOND);
    ctl(8'h03, 1'b0);
    key(twu_pkg::KEY_SECOND);
    ctl(8'h03, 1'b0);
    axi_write(KEY_A, twu_pkg::KEY_FIRST, 4'h0, OK);
    key(twu_pkg::KEY_SECOND);
    ctl(8'h03, 1'b0);
    axi_write(12'h100, 8'hff, 4'hf, twu_pkg::RESP_DECERR);
    axi_read(12'h100, 32'h0000_0000, twu_pkg::RESP_DECERR);
    axi_read(KEY_A, 32'h0000_0000, OK);
  endtask : t_misc

  task automatic t_power;
    pfail <= 1'b1;
    @(posedge clock_i);
    pfail <= 1'b0;
    @(posedge clock_i);
    exp_ctrl.por_flag = 1'b1;
    check(32'(ctrl), 32'(exp_ctrl));
    t_unlock(0, 0, 8'h00, 1'b1);
  endtask : t_power

  initial begin
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    check(32'(ctrl), 32'(twu_pkg::CTRL_RESET));
    check(32'(sts), 32'h0000_0000);
    ctl(8'h1f, 1'b0);
    t_unlock(0, 0, 8'h1f, 1'b1);
    t_unlock(1, 1, 8'h0a, 1'b1);
    t_unlock(0, 2, 8'h15, 1'b0);
    t_unlock(2, 0, 8'h06, 1'b0);
    t_unlock(1, 0, 8'h17, 1'b1);
    t_misc();
    t_power();
    report_and_stop();
  end
endmodule : tb_twu_top

// ==== sim/twu_top_sva.sv ====
// Port-level checks for the timed write unlock guard
`timescale 1ns/10ps
module twu_top_sva #(
  parameter int AW = twu_pkg::ADDR_W
) (
  input wire logic                    clock_i,
  input wire logic                    arst_n_i,
  input wire logic [AW-1:0]           s_axi_awaddr,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [31:0]             s_axi_wdata,
  input wire logic [3:0]              s_axi_wstrb,
  input wire logic                    s_axi_wvalid,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    power_fail_i,
  input wire twu_pkg::twu_ctrl_type   ctrl_o,
  input wire twu_pkg::twu_status_type status_o
);
  wire       wr_take = s_axi_awvalid & s_axi_wvalid & s_axi_awready;
  wire [7:0] wr_idx  = s_axi_awaddr[9:2];
  wire       key_wr  = wr_take & s_axi_wstrb[0] & (wr_idx == twu_pkg::UNLOCK_KEY_IDX);
  wire       ctl_wr  = wr_take & s_axi_wstrb[0] & (wr_idx == twu_pkg::WD_CTRL_IDX);
  wire       key_aa  = key_wr & (s_axi_wdata[7:0] == twu_pkg::KEY_FIRST);
  wire       key_55  = key_wr & (s_axi_wdata[7:0] == twu_pkg::KEY_SECOND);
  wire       opening = key_55 & status_o.armed;
  wire       unmapped = !(wr_idx inside {twu_pkg::UNLOCK_KEY_IDX, twu_pkg::WD_CTRL_IDX,
                                         twu_pkg::GUARD_STATUS_IDX});
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Key sequences left alone by later key writes
  sequence arm_idle_s;
    key_aa ##1 !key_wr [*3];
  endsequence
  sequence open_idle_s;
    opening ##1 !key_wr [*3];
  endsequence
  resp_follows_a: assert property (wr_take |=> s_axi_bvalid) else $error("no write response");
  unmapped_decerr_a: assert property (wr_take && unmapped |=> s_axi_bresp == twu_pkg::RESP_DECERR)
    else $error("unmapped write not refused");
  arm_start_a: assert property (key_aa |=> status_o.armed) else $error("first key did not arm");
  arm_expire_a: assert property (arm_idle_s |-> status_o.armed ##1 !status_o.armed)
    else $error("arming length wrong");
  window_open_a: assert property (opening |=> status_o.window_open)
    else $error("second key did not open");
  window_width_a: assert property (open_idle_s |-> status_o.window_open ##1 !status_o.window_open)
    else $error("window length wrong");
  ctrl_land_a: assert property (ctl_wr && status_o.window_open |=>
    ctrl_o[4:0] == $past(s_axi_wdata[4:0])) else $error("open write lost");
  ctrl_drop_a: assert property (ctl_wr && !status_o.window_open && !power_fail_i |=>
    $stable(ctrl_o)) else $error("closed write landed");
  bad_key_a: assert property (key_wr && !key_aa && !key_55 |=>
    !status_o.window_open && !status_o.armed) else $error("wrong key kept sequence");
endmodule : twu_top_sva

bind twu_top twu_top_sva #(.AW(AW)) twu_top_sva_i (.clock_i, .arst_n_i, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp,
  .s_axi_bvalid, .power_fail_i, .ctrl_o, .status_o);
